// file: design/ssi_i2c_engine.sv
// Byte-level I2C master on the link clock, open-drain pins.
// Assumes a request toggle with a command held stable until done.
module ssi_i2c_engine (
  // Link clock and reset
  input wire logic linkClk,
  input wire logic resetn,
  // Request and answer
  input wire logic reqTgl,
  input wire ssi_pkg::ssi_cmd_t cmd,
  output logic doneTgl,
  output ssi_pkg::ssi_rsp_t rsp,
  // Bus pins
  input wire logic sclI,
  output logic sclO,
  output logic sclOe,
  input wire logic sdaI,
  output logic sdaO,
  output logic sdaOe
);
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_START = 3'h1, E_SEND = 3'h3,
    E_RECV = 3'h2, E_STOP = 3'h6, E_DONE = 3'h7
  } ssi_eng_t;
  ssi_eng_t st_q, st_d;
  ssi_pkg::ssi_cmd_t cmd_q, cmd_d;
  logic [1:0] rst_q, qtr_q, qtr_d, ph_q, ph_d, sda_q, scl_q;
  logic [2:0] req_q, div_q, idx_q, idx_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [63:0] rx_q, rx_d;
  logic nack_q, nack_d, done_q, done_d, sclL, sdaL, sclOe_q, sdaOe_q, sdaDly_q;
  logic linkRstn, tick, adv, lastByte;

  // ==========================================
  // Reset release and pin synchronisers
  assign linkRstn = rst_q[1];
  always_ff @(posedge linkClk or negedge resetn)
    if (!resetn)
    begin
      rst_q <= 2'h0;
      req_q <= 3'h0;
      sda_q <= 2'h3;
      scl_q <= 2'h3;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'h1};
      req_q <= {req_q[1:0], reqTgl};
      sda_q <= {sda_q[0], sdaI};
      scl_q <= {scl_q[0], sclI};
    end

  // Quarter ticks, held while SCL is released but still low
  // Covers start and stop too, so their SDA edge waits for SCL high
  assign tick = div_q == 3'(ssi_pkg::QTR_CYC - 1);
  assign adv = tick && (sclOe_q || scl_q[1]);
  assign lastByte = {1'h0, idx_q} == cmd_q.nBytes - 4'h1;

  // Pin levels and byte sequencing
  always_comb
  begin
    st_d = st_q; cmd_d = cmd_q; qtr_d = qtr_q; ph_d = ph_q; idx_d = idx_q;
    bit_d = bit_q; sh_d = sh_q; rx_d = rx_q; nack_d = nack_q; done_d = done_q;
    sclL = 1'h1;
    sdaL = 1'h1;
    if (adv && st_q != E_IDLE && st_q != E_DONE)
      qtr_d = qtr_q + 2'h1;
    case (st_q)
      E_IDLE:
        if (req_q[2] ^ req_q[1])
        begin
          cmd_d = cmd; st_d = E_START; qtr_d = 2'h0;
          ph_d = 2'h0; idx_d = 3'h0; bit_d = 4'h0; nack_d = 1'h0;
        end
      E_START:
      begin
        sclL = qtr_q == 2'h1 || qtr_q == 2'h2;
        sdaL = !qtr_q[1];
        if (adv && qtr_q == 2'h3)
        begin
          st_d = E_SEND;
          sh_d = {cmd_q.dev, ph_q == 2'h3 ? ssi_pkg::RW_RD : ssi_pkg::RW_WR};
        end
      end
      E_SEND:
      begin
        sclL = qtr_q[1];
        sdaL = bit_q[3] | sh_q[7];
        if (adv && qtr_q == 2'h2 && bit_q[3] && sda_q[1])
          nack_d = 1'h1;
        if (adv && qtr_q == 2'h3)
        begin
          bit_d = bit_q[3] ? 4'h0 : bit_q + 4'h1;
          sh_d = {sh_q[6:0], 1'h0};
          if (bit_q[3])
          begin
            if (nack_q)
              st_d = E_STOP;
            else if (ph_q == 2'h0)
            begin
              sh_d = cmd_q.regAddr;
              ph_d = 2'h1;
            end
            else if (ph_q == 2'h1 && cmd_q.rd)
            begin
              st_d = E_START;
              ph_d = 2'h3;
            end
            else if (ph_q == 2'h1)
            begin
              sh_d = cmd_q.wrData;
              ph_d = 2'h2;
            end
            else if (ph_q == 2'h2)
              st_d = E_STOP;
            else
              st_d = E_RECV;
          end
        end
      end
      E_RECV:
      begin
        sclL = qtr_q[1];
        sdaL = !bit_q[3] || lastByte;
        if (adv && qtr_q == 2'h2 && !bit_q[3])
          sh_d = {sh_q[6:0], sda_q[1]};
        if (adv && qtr_q == 2'h3)
        begin
          bit_d = bit_q[3] ? 4'h0 : bit_q + 4'h1;
          if (bit_q[3])
          begin
            rx_d[{idx_q, 3'h0} +: 8] = sh_q;
            idx_d = idx_q + 3'h1;
            if (lastByte)
              st_d = E_STOP;
          end
        end
      end
      E_STOP:
      begin
        sclL = qtr_q != 2'h0;
        sdaL = qtr_q[1];
        if (adv && qtr_q == 2'h3)
          st_d = E_DONE;
      end
      default:
      begin
        done_d = !done_q;
        st_d = E_IDLE;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge linkClk or negedge linkRstn)
    if (!linkRstn)
    begin
      st_q <= E_IDLE; cmd_q <= '0; qtr_q <= 2'h0; ph_q <= 2'h0; idx_q <= 3'h0;
      bit_q <= 4'h0; sh_q <= 8'h00; rx_q <= ssi_pkg::DATA_RST; nack_q <= 1'h0;
      done_q <= 1'h0; div_q <= 3'h0; sclOe_q <= 1'h0; sdaOe_q <= 1'h0; sdaDly_q <= 1'h0;
    end
    else
    begin
      st_q <= st_d; cmd_q <= cmd_d; qtr_q <= qtr_d; ph_q <= ph_d; idx_q <= idx_d;
      bit_q <= bit_d; sh_q <= sh_d; rx_q <= rx_d; nack_q <= nack_d; done_q <= done_d;
      div_q <= tick ? 3'h0 : div_q + 3'h1;
      sclOe_q <= !sclL;
      sdaDly_q <= !sdaL;
      sdaOe_q <= sdaDly_q; // SDA moves a link cycle after SCL falls
    end

  assign doneTgl = done_q;
  assign rsp = '{nack: nack_q, data: rx_q};
  assign sclOe = sclOe_q;
  assign sdaOe = sdaOe_q;
  assign sclO = 1'h0;
  assign sdaO = 1'h0;

  // ==========================================
  // Checks
  sequence quietQuarter;
    !tick [*4];
  endsequence
  a_quarter_rate: assert property (@(posedge linkClk) disable iff (!linkRstn)
    tick |=> quietQuarter ##1 tick) else $error("quarter period wrong");
  a_addr_first: assert property (@(posedge linkClk) disable iff (!linkRstn)
    st_q == E_START && adv && qtr_q == 2'h3 |=> sh_q[7:1] == cmd_q.dev)
    else $error("address byte wrong");
  a_write_one: assert property (@(posedge linkClk) disable iff (!linkRstn)
    st_q == E_SEND && ph_q == 2'h2 && bit_q[3] && adv && qtr_q == 2'h3 |=> st_q == E_STOP)
    else $error("write not one byte");
  a_stop_done: assert property (@(posedge linkClk) disable iff (!linkRstn)
    st_q == E_STOP && adv && qtr_q == 2'h3 |=> st_q == E_DONE ##1 doneTgl != $past(doneTgl))
    else $error("stop not followed by done");
endmodule

// file: design/ssi_pkg.sv
// Shared constants and carriers for the secondary sensor master.
// Assumes a 10 MHz register clock and an 8 MHz link clock.
package ssi_pkg;
  // ==========================================
  // Clock rates and timing
  localparam int unsigned REF_HZ = 10_000_000;
  localparam int unsigned LINK_HZ = 8_000_000;
  localparam int unsigned SCL_HZ = 400_000;
  localparam int unsigned QTR_CYC = LINK_HZ / (4 * SCL_HZ);
  localparam int unsigned STEP_US = 2500;
  localparam int unsigned STEP_CYC = REF_HZ / 1_000_000 * STEP_US;
  localparam int unsigned PERIOD_US = 40000;
  localparam int unsigned PERIOD_CYC = REF_HZ / 1_000_000 * PERIOD_US;
  // ==========================================
  // Field values and reset values
  localparam logic RW_WR = 1'h0;
  localparam logic RW_RD = 1'h1;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [63:0] DATA_RST = 64'h0;
  // ==========================================
  // Types
  typedef logic [23:0] ssi_cnt_t;
  typedef enum logic [1:0] {
    MD_NONE = 2'h0,
    MD_SETUP = 2'h1,
    MD_DATA = 2'h3
  } ssi_mode_t;
  typedef struct packed {
    logic rd;
    logic [6:0] dev;
    logic [7:0] regAddr;
    logic [7:0] wrData;
    logic [3:0] nBytes;
  } ssi_cmd_t;
  typedef struct packed {
    logic nack;
    logic [63:0] data;
  } ssi_rsp_t;
  // Burst length code to byte count
  function automatic logic [3:0] burstBytes(input logic [1:0] c);
    case (c)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction
endpackage

// file: design/ssi_sensor_master.sv
// Secondary sensor master: mode decode, manual access, data loop.
// Assumes host strobes on ref_clk and a free link clock.

module ssi_sensor_master #(
  parameter int unsigned STEP_CYCLES = ssi_pkg::STEP_CYC,
  parameter int unsigned PERIOD_CYCLES = ssi_pkg::PERIOD_CYC
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic linkClk,
  // Mode control
  input wire logic ifMode,
  input wire logic manualEn,
  input wire logic advPowerSave,
  input wire logic auxEn,
  // Sensor configuration
  input wire logic [6:0] devAddr,
  input wire logic [1:0] burstCode,
  input wire logic [3:0] offsetCode,
  // Indirect access
  input wire logic [7:0] ptrData,
  input wire logic rdPtrWr,
  input wire logic wrPtrWr,
  input wire logic [7:0] wrByte,
  input wire logic sampleRead,
  // Status and data
  output ssi_pkg::ssi_mode_t mode,
  output logic manualTransferActive,
  output logic sampleReady,
  output logic [63:0] sampleData,
  output logic nackSeen,
  // FIFO write side
  output logic fifoValid,
  output logic [63:0] fifoData,
  // Secondary bus pins
  input wire logic sclI,
  output logic sclO,
  output logic sclOe,
  input wire logic sdaI,
  output logic sdaO,
  output logic sdaOe
);
  // ==========================================
  // Declarations
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_TRIG = 3'h1,
    S_WAIT = 3'h3,
    S_READ = 3'h2,
    S_GAP = 3'h6,
    S_MAN = 3'h4
  } ssi_seq_t;
  ssi_seq_t st_q, st_d;
  ssi_pkg::ssi_cnt_t cnt_q, cnt_d;
  ssi_pkg::ssi_cmd_t cmd_q, cmd_d;
  ssi_pkg::ssi_rsp_t rsp;
  ssi_pkg::ssi_mode_t mode_q, mode_d;
  logic [2:0] done_q;
  logic [7:0] rdAddr_q, rdAddr_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [63:0] sample_q, sample_d;
  logic [63:0] fifoD_q, fifoD_d;
  logic req_q, req_d;
  logic man_q, man_d;
  logic ready_q, ready_d;
  logic fifoV_q, fifoV_d;
  logic nack_q, nack_d;
  logic doneTgl;
  logic doneEv;
  logic dataMode;
  logic manTrig;
  logic store;
  logic push;

  // ==========================================
  // Helper functions
  // Mode from the four control bits
  function automatic ssi_pkg::ssi_mode_t modeOf(
    input logic en, input logic man, input logic aps, input logic aux);
    if (!en)
      return ssi_pkg::MD_NONE;
    else if (!man && aux)
      return ssi_pkg::MD_DATA;
    else if (man && !aps && !aux)
      return ssi_pkg::MD_SETUP;
    return ssi_pkg::MD_NONE;
  endfunction

  // Command for one secondary bus transfer
  function automatic ssi_pkg::ssi_cmd_t mkCmd(
    input logic rd, input logic [7:0] addr);
    ssi_pkg::ssi_cmd_t c;
    c.rd = rd;
    c.dev = devAddr;
    c.regAddr = addr;
    c.wrData = wrByte;
    c.nBytes = ssi_pkg::burstBytes(burstCode);
    return c;
  endfunction

  // Wait from trigger to read
  function automatic ssi_pkg::ssi_cnt_t delayCyc(input logic [3:0] c);
    if (c == 4'h0)
      return ssi_pkg::ssi_cnt_t'(PERIOD_CYCLES);
    return ssi_pkg::ssi_cnt_t'(c * STEP_CYCLES);
  endfunction

  // Wait from update to next trigger
  function automatic ssi_pkg::ssi_cnt_t gapCyc(input logic [3:0] c);
    if (c == 4'h0)
      return ssi_pkg::ssi_cnt_t'(1);
    return ssi_pkg::ssi_cnt_t'(PERIOD_CYCLES - c * STEP_CYCLES);
  endfunction

  // ==========================================
  // Link-side engine and crossing
  ssi_i2c_engine u_eng (
    .linkClk(linkClk),
    .resetn(resetn),
    .reqTgl(req_q),
    .cmd(cmd_q),
    .doneTgl(doneTgl),
    .rsp(rsp),
    .sclI(sclI),
    .sclO(sclO),
    .sclOe(sclOe),
    .sdaI(sdaI),
    .sdaO(sdaO),
    .sdaOe(sdaOe)
  );

  // Done toggle synchroniser; answer word is stable by then
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      done_q <= 3'h0;
    else
      done_q <= {done_q[1:0], doneTgl};
  assign doneEv = done_q[2] ^ done_q[1];

  // ==========================================
  // Mode decode
  assign dataMode = mode_q == ssi_pkg::MD_DATA;
  assign manTrig = ifMode && manualEn && !advPowerSave && auxEn
    && (rdPtrWr || wrPtrWr);
  always_comb
  begin
    mode_d = modeOf(ifMode, manualEn, advPowerSave, auxEn);
    rdAddr_d = rdPtrWr ? ptrData : rdAddr_q;
    wrAddr_d = wrPtrWr ? ptrData : wrAddr_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      mode_q <= ssi_pkg::MD_NONE;
      rdAddr_q <= ssi_pkg::PTR_RST;
      wrAddr_q <= ssi_pkg::PTR_RST;
    end
    else
    begin
      mode_q <= mode_d;
      rdAddr_q <= rdAddr_d;
      wrAddr_q <= wrAddr_d;
    end

  // ==========================================
  // Transfer sequencer
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    req_d = req_q;
    cmd_d = cmd_q;
    man_d = man_q;
    store = 1'h0;
    push = 1'h0;
    case (st_q)
      S_IDLE:
        if (manTrig)
        begin
          cmd_d = mkCmd(rdPtrWr, ptrData);
          req_d = !req_q;
          man_d = 1'h1;
          st_d = S_MAN;
        end
        else if (dataMode)
        begin
          cmd_d = mkCmd(ssi_pkg::RW_WR, wrAddr_q);
          req_d = !req_q;
          st_d = S_TRIG;
        end
      S_MAN:
        if (doneEv)
        begin
          man_d = 1'h0;
          store = cmd_q.rd;
          st_d = S_IDLE;
        end
      S_TRIG:
        if (doneEv)
        begin
          cnt_d = delayCyc(offsetCode);
          st_d = S_WAIT;
        end
      S_WAIT:
        if (!dataMode)
          st_d = S_IDLE;
        else if (cnt_q <= 24'h1)
        begin
          cmd_d = mkCmd(ssi_pkg::RW_RD, rdAddr_q);
          req_d = !req_q;
          st_d = S_READ;
        end
        else
          cnt_d = cnt_q - 24'h1;
      S_READ:
        if (doneEv)
        begin
          store = 1'h1;
          push = 1'h1;
          cnt_d = gapCyc(offsetCode);
          st_d = S_GAP;
        end
      default:
        if (!dataMode)
          st_d = S_IDLE;
        else if (cnt_q <= 24'h1)
        begin
          cmd_d = mkCmd(ssi_pkg::RW_WR, wrAddr_q);
          req_d = !req_q;
          st_d = S_TRIG;
        end
        else
          cnt_d = cnt_q - 24'h1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      req_q <= 1'h0;
      cmd_q <= '0;
      man_q <= 1'h0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      cmd_q <= cmd_d;
      man_q <= man_d;
    end

  // ==========================================
  // Sample registers, ready flag, FIFO push
  always_comb
  begin
    sample_d = store ? rsp.data : sample_q;
    ready_d = store | (ready_q & !sampleRead);
    nack_d = doneEv ? rsp.nack : nack_q;
    fifoV_d = push;
    fifoD_d = push ? rsp.data : fifoD_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      sample_q <= ssi_pkg::DATA_RST;
      ready_q <= 1'h0;
      nack_q <= 1'h0;
      fifoV_q <= 1'h0;
      fifoD_q <= ssi_pkg::DATA_RST;
    end
    else
    begin
      sample_q <= sample_d;
      ready_q <= ready_d;
      nack_q <= nack_d;
      fifoV_q <= fifoV_d;
      fifoD_q <= fifoD_d;
    end

  assign mode = mode_q;
  assign manualTransferActive = man_q;
  assign sampleReady = ready_q;
  assign sampleData = sample_q;
  assign nackSeen = nack_q;
  assign fifoValid = fifoV_q;
  assign fifoData = fifoD_q;

  // ==========================================
  // Checks
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence waitOver;
    st_q == S_WAIT && cnt_q == 24'h1 && dataMode;
  endsequence

  a_mode_off: assert property (!ifMode |=> mode == ssi_pkg::MD_NONE)
    else $error("mode active while port disabled");
  a_mode_data: assert property (ifMode && !manualEn && auxEn |=> mode == ssi_pkg::MD_DATA)
    else $error("data mode not decoded");
  a_man_start: assert property (st_q == S_IDLE && manTrig |=>
    manualTransferActive && req_q != $past(req_q)) else $error("manual trigger lost");
  a_man_end: assert property (st_q == S_MAN && doneEv |=> !manualTransferActive)
    else $error("manual flag not cleared");
  a_ready_set: assert property (store |=> sampleReady && sampleData == $past(rsp.data))
    else $error("sample not stored");
  a_ready_clear: assert property (sampleRead && !store |=> !sampleReady)
    else $error("ready not cleared by read");
  a_wait_read: assert property (waitOver |=> st_q == S_READ && cmd_q.rd
    && cmd_q.regAddr == rdAddr_q) else $error("read not issued after delay");
  a_fifo_copy: assert property (fifoValid |-> fifoData == sampleData && sampleReady)
    else $error("fifo word differs from sample");
endmodule

// file: verification/ssi_sensor_model.sv
// Behavioural sensor on the secondary I2C bus with a 256-byte register map.
// Assumes pull-ups on both lines; the model only pulls them low.
module ssi_sensor_model #(
  parameter logic [6:0] ADDR = 7'h12
) (
  // Bus levels and pull-low enables
  input wire logic scl,
  input wire logic sda,
  output logic sclPull,
  output logic sdaPull,
  // Slow answer by clock stretching
  input wire logic stretch
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Register map and bus state
  logic [7:0] mem [256];
  logic [7:0] sh = 8'h00, ptr = 8'h00;
  logic act = 1'h0, sel = 1'h0, rd = 1'h0;
  int bitN = 0, byteN = 0, wrBytes = 0;
  realtime tWr = 0, tStart = 0, tLast = 0, minPer = 1e9;
  initial {sclPull, sdaPull} = 2'h0;
  // Start and stop detection, sole device on the bus
  always @(sda)
  begin
    if (scl === 1'h1 && sda === 1'h0)
    begin
      if (!act)
        tStart = $realtime;
      act = 1'h1;
      sel = 1'h0;
      rd = 1'h0;
      bitN = 0;
      byteN = 0;
    end
    else if (scl === 1'h1)
      act = 1'h0;
  end
  // Shift in bits, handle address, pointer, data and master ack
  always @(posedge scl)
  begin
    if (act && bitN > 0 && $realtime - tLast < minPer)
      minPer = $realtime - tLast;
    tLast = $realtime;
    if (act && bitN < 8)
    begin
      sh = {sh[6:0], sda};
      bitN++;
    end
    else if (act)
    begin
      if (byteN == 0)
      begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      else if (rd && sel)
      begin
        if (sda)
          sel = 1'h0;
        else
          ptr++;
      end
      else if (sel && byteN == 1)
        ptr = sh;
      else if (sel)
      begin
        mem[ptr] = sh;
        ptr++;
        wrBytes++;
        tWr = $realtime;
      end
      bitN = 0;
      byteN++;
    end
  end
  // Drive ack or read data while the clock is low, then maybe stretch
  always @(negedge scl)
  begin
    if (!act)
      sdaPull <= 1'h0;
    else if (bitN == 8)
      sdaPull <= (byteN == 0) ? (sh[7:1] == ADDR) : (sel && !rd);
    else
      sdaPull <= sel && rd && !mem[ptr][7 - bitN];
    if (stretch)
    begin
      sclPull = 1'h1;
      #2000;
      sclPull = 1'h0;
    end
  end
endmodule

// file: verification/test_ssi_sensor_master.sv
// Self-checking bench for the secondary sensor master.
// Assumes ssi_pkg, the design and ssi_sensor_model are compiled first.
module test_ssi_sensor_master;
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Stimulus and observed signals
  localparam int STEP = 20;
  localparam int PER = 400;
  localparam logic [6:0] SENSOR = 7'h12;
  logic ref_clk = 1'h0, linkClk = 1'h1, resetn = 1'h0;
  logic ifMode = 1'h0, manualEn = 1'h1, advPowerSave = 1'h1, auxEn = 1'h0;
  logic [6:0] devAddr = SENSOR;
  logic [1:0] burstCode = 2'h0;
  logic [3:0] offsetCode = 4'h0;
  logic [7:0] ptrData = 8'h00, wrByte = 8'h00;
  logic rdPtrWr = 1'h0, wrPtrWr = 1'h0, sampleRead = 1'h0, stretch = 1'h0;
  ssi_pkg::ssi_mode_t mode;
  logic manualTransferActive, sampleReady, nackSeen, fifoValid;
  logic [63:0] sampleData, fifoData;
  logic sclO, sclOe, sdaO, sdaOe, sclPull, sdaPull, sclW, sdaW;
  int miscompares = 0;
  int n_checks = 0;
  // Open-drain lines with pull-ups
  assign sclW = !(sclOe || sclPull);
  assign sdaW = !(sdaOe || sdaPull);
  // Register clock 100 ns, link clock 125 ns
  always #50 ref_clk = !ref_clk;
  always #62.5 linkClk = !linkClk;
  // Device and sensor
  ssi_sensor_master #(.STEP_CYCLES(STEP), .PERIOD_CYCLES(PER)) i_ssi_sensor_master (
    .ref_clk, .resetn, .linkClk, .ifMode, .manualEn, .advPowerSave, .auxEn, .devAddr,
    .burstCode, .offsetCode, .ptrData, .rdPtrWr, .wrPtrWr, .wrByte, .sampleRead, .mode,
    .manualTransferActive, .sampleReady, .sampleData, .nackSeen, .fifoValid, .fifoData,
    .sclI(sclW), .sclO, .sclOe, .sdaI(sdaW), .sdaO, .sdaOe);
  ssi_sensor_model #(.ADDR(SENSOR)) i_ssi_sensor_model (
    .scl(sclW), .sda(sdaW), .sclPull, .sdaPull, .stretch);
  // ======
  // Helpers
  function automatic logic [7:0] pat(input int a);
    return 8'(a * 7 + 3);
  endfunction
  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic waitFor(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("wait", 64'(s), 64'(v));
  endtask
  task automatic setMode(input logic [3:0] m);
    @(posedge ref_clk);
    {ifMode, manualEn, advPowerSave, auxEn} <= m;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic trig(input logic rd, input logic [7:0] p);
    @(posedge ref_clk);
    ptrData <= p;
    rdPtrWr <= rd;
    wrPtrWr <= !rd;
    @(posedge ref_clk);
    rdPtrWr <= 1'h0;
    wrPtrWr <= 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic manual(input logic rd, input logic [7:0] p, input logic busy);
    trig(rd, p);
    check("busy", 64'(manualTransferActive), 64'(busy));
    waitFor(manualTransferActive, 1'h0, 6000);
  endtask
  task automatic readSample();
    @(posedge ref_clk);
    sampleRead <= 1'h1;
    @(posedge ref_clk);
    sampleRead <= 1'h0;
    @(negedge ref_clk);
  endtask
  // Watchdog well beyond the expected run of about 2 ms
  initial
  begin
    #8_000_000;
    miscompares++;
    print_verdict();
  end
  // ======
  // Test sequence
  initial
  begin
    logic [63:0] exp;
    logic [63:0] mask;
    int nb[4] = '{1, 2, 6, 8};
    int w0;
    realtime d0;
    realtime d1;
    for (int i = 0; i < 256; i++)
      i_ssi_sensor_model.mem[i] = pat(i);
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (6) @(negedge ref_clk);
    check("mode", 64'(mode), 64'h0);
    check("busPins", {60'h0, sclO, sdaO, sclOe, sdaOe}, 64'h0);
    check("ready", 64'(sampleReady), 64'h0);
    // Mode table and a disabled port
    setMode(4'he);
    check("mode", 64'(mode), 64'(ssi_pkg::MD_NONE));
    setMode(4'hc);
    check("mode", 64'(mode), 64'(ssi_pkg::MD_SETUP));
    setMode(4'h5);
    manual(1'h1, 8'h20, 1'h0);
    // Wrong slave address gets no acknowledge
    setMode(4'hd);
    @(posedge ref_clk);
    devAddr <= 7'h13;
    manual(1'h1, 8'h10, 1'h1);
    check("nack", 64'(nackSeen), 64'h1);
    // Write, with a second trigger while busy that must be ignored
    @(posedge ref_clk);
    devAddr <= SENSOR;
    wrByte <= 8'ha5;
    w0 = i_ssi_sensor_model.wrBytes;
    trig(1'h0, 8'h4c);
    check("busy", 64'(manualTransferActive), 64'h1);
    manual(1'h0, 8'h4d, 1'h1);
    check("wrMem", 64'(i_ssi_sensor_model.mem[8'h4c]), 64'ha5);
    check("skipMem", 64'(i_ssi_sensor_model.mem[8'h4d]), 64'(pat(8'h4d)));
    check("wrBytes", 64'(i_ssi_sensor_model.wrBytes - w0), 64'h1);
    check("nack", 64'(nackSeen), 64'h0);
    check("sclPer", 64'(int'(i_ssi_sensor_model.minPer)), 64'h9c4);
    // Manual reads for every burst length
    for (int c = 0; c < 4; c++)
    begin
      @(posedge ref_clk);
      burstCode <= 2'(c);
      manual(1'h1, 8'(16 + 8 * c), 1'h1);
      mask = ~64'h0 >> (64 - 8 * nb[c]);
      for (int i = 0; i < 8; i++)
        exp[8*i +: 8] = pat(16 + 8 * c + i);
      check("rdData", sampleData & mask, exp & mask);
      check("ready", 64'(sampleReady), 64'h1);
      readSample();
      check("ready", 64'(sampleReady), 64'h0);
    end
    // Data mode: pointers set with the port off, then the autonomous loop
    setMode(4'h3);
    trig(1'h1, 8'h42);
    trig(1'h0, 8'h4b);
    @(posedge ref_clk);
    wrByte <= 8'h01;
    offsetCode <= 4'h3;
    burstCode <= 2'h3;
    stretch <= 1'h1;
    setMode(4'hb);
    check("mode", 64'(mode), 64'(ssi_pkg::MD_DATA));
    d0 = 0;
    for (int k = 0; k < 2; k++)
    begin
      waitFor(fifoValid, 1'h1, 20000);
      for (int i = 0; i < 8; i++)
        exp[8*i +: 8] = pat(8'h42 + i) ^ {8{k[0]}};
      check("fifo", fifoData, exp);
      check("data", sampleData, exp);
      d1 = i_ssi_sensor_model.tStart - i_ssi_sensor_model.tWr;
      if (k == 0)
        check("delay", 64'(d1 >= 6000.0), 64'h1);
      else
        check("delayStep", 64'(d1 - d0 > 7400.0 && d1 - d0 < 8600.0), 64'h1);
      d0 = d1;
      @(negedge ref_clk);
      check("pulse", 64'(fifoValid), 64'h0);
      check("ready", 64'(sampleReady), 64'h1);
      @(posedge ref_clk);
      offsetCode <= 4'h7;
      for (int i = 0; i < 8; i++)
        i_ssi_sensor_model.mem[8'h42 + i] = ~pat(8'h42 + i);
    end
    check("trigMem", 64'(i_ssi_sensor_model.mem[8'h4b]), 64'h1);
    setMode(4'h9);
    check("mode", 64'(mode), 64'(ssi_pkg::MD_DATA));
    print_verdict();
  end
endmodule
